/* File: pcmg_pkg.sv */
/*
 * pcmg_pkg: shared constants for the pipe colour matrix and gamut block.
 * assumes: byte addresses on an 8-bit apb address, 32-bit data, one word per register.
 */
package pcmg_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_MODE = 8'h00; // matrix mode, write arms the update
	localparam logic [7:0] ADDR_PIPECFG = 8'h04; // pipe config, split gamma
	localparam logic [7:0] ADDR_GAMUT = 8'h08; // gamut enhance control
	localparam logic [7:0] ADDR_STATUS = 8'h0c; // update pending status
	localparam logic [7:0] ADDR_IN_OFF = 8'h10; // three input offsets, high first
	localparam logic [7:0] ADDR_OUT_OFF = 8'h1c; // three output offsets, high first
	localparam logic [7:0] ADDR_COEF = 8'h28; // nine coefficients, row major, high row first
	localparam logic [7:0] ADDR_WEIGHT = 8'h80; // sixteen weights up to 8'hbc
	localparam logic [7:0] ADDR_WEIGHT_END = 8'hc0; // first address past the weights
	// field positions
	localparam int MODE_AFTER_BIT = 0; // 1 = gamma after matrix
	localparam int PIPECFG_SPLIT_BIT = 0; // 1 = split gamma
	localparam int GAMUT_EN_BIT = 0; // 1 = gamut enhancement on
	localparam int STATUS_PEND_BIT = 0; // 1 = staged settings wait for vblank
	// coefficient format: signed, 12 fraction bits
	localparam int COEF_W = 16;
	localparam int COEF_FRAC = 12;
	localparam logic [15:0] COEF_ONE = 16'h1000; // reset value on the diagonal
	localparam logic [15:0] COEF_ZERO = 16'h0000; // reset value off the diagonal
	// gamut weight table
	localparam int WEIGHT_W = 6;
	localparam int WEIGHT_N = 16;
	localparam int WEIGHT_IDX_W = 4;
	localparam logic [5:0] WEIGHT_MAX = 6'h20; // all input colour
	localparam int WEIGHT_SHIFT = 5; // weight full scale is 2**5
	// fixed datapath latency in clocks
	localparam int LATENCY = 5;
endpackage

/* File: pcmg_weight_mem.sv */
/*
 * pcmg_weight_mem: the saturation-indexed weight table with one write and one read port.
 * assumes: one clock; the reader takes data one clock after presenting the address.
 */
`timescale 1ns/1ps
module pcmg_weight_mem #(
	parameter int DW = 6,
	parameter int AW = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem_q [2**AW]; // weight entries

	// writes from the register bus
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// read data comes out of a register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule

/* File: pcmg_matrix_row.sv */
/*
 * pcmg_matrix_row: one output channel of the colour matrix, three products summed.
 * assumes: signed inputs and coefficients; result registered, one clock of latency.
 */
`timescale 1ns/1ps
module pcmg_matrix_row #(
	parameter int IW = 13,
	parameter int OW = 17
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic signed [IW-1:0] in_high,
	input wire logic signed [IW-1:0] in_med,
	input wire logic signed [IW-1:0] in_low,
	input wire logic signed [pcmg_pkg::COEF_W-1:0] coef_first,
	input wire logic signed [pcmg_pkg::COEF_W-1:0] coef_second,
	input wire logic signed [pcmg_pkg::COEF_W-1:0] coef_third,
	output logic signed [OW-1:0] result
);
	localparam int PW = IW + pcmg_pkg::COEF_W; // product width
	localparam int SW = PW + 2; // sum width
	logic signed [PW-1:0] prod_high; // first coefficient times high input
	logic signed [PW-1:0] prod_med; // second coefficient times medium input
	logic signed [PW-1:0] prod_low; // third coefficient times low input
	logic signed [SW-1:0] sum; // three products summed

	// first coefficient meets high, second medium, third low; products at full width
	always_comb begin
		prod_high = coef_first * in_high;
		prod_med = coef_second * in_med;
		prod_low = coef_third * in_low;
		sum = SW'(prod_high) + SW'(prod_med) + SW'(prod_low);
	end

	// drop the fraction bits and register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= '0;
		end else begin
			result <= sum[pcmg_pkg::COEF_FRAC +: OW];
		end
	end
endmodule

/* File: pcmg_top.sv */
/*
 * pcmg_top: per-pipe colour path: gamma placement, 3x3 matrix with offsets,
 * clamp after the output offset, gamut enhancement blend; registers on an apb slave.
 * assumes: pixels, sync and the vblank pulse all run on pclk; the gamma
 * curve here is a fixed square law standing in for the palette stage.
 */
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
// Function
// - msbs high, lsbs low, middle is medium
// - rgb and yuv carried on fixed channels
// - matrix settings double buffered, load at vblank
// - high output is high-row products summed
// - medium output is medium-row products summed
// - low output is low-row products summed
// - per-channel input offset before the multiply
// - per-channel output offset after the multiply
// - gamma-before mode: gamma then matrix
// - gamma-after mode: matrix then gamma
// - split gamma: stages before and after matrix
// - split gamma: both stages or neither
// - final result clamped to zero..one; the code clamps at stage 4, before gamma-after and the blend
// - enhancement uses input and corrected colour
// - input saturation indexes the weight table
// - weight blends corrected and input linearly
module pcmg_top #(
	parameter int CW = 10,
	parameter int SYNC_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic vblank_start,
	input wire logic pix_in_valid,
	input wire logic [3*CW-1:0] pix_in,
	input wire logic pix_in_gamma_en,
	input wire logic [SYNC_W-1:0] pix_in_sync,
	output logic pix_out_valid,
	output logic [3*CW-1:0] pix_out,
	output logic [SYNC_W-1:0] pix_out_sync
);
	localparam int IW = CW + 3; // signed offset-added channel
	localparam int OW = CW + 7; // signed matrix result
	localparam int OFW = CW + 2; // signed offset field
	localparam int NS = pcmg_pkg::LATENCY; // pipeline depth
	localparam logic [CW-1:0] CMAX = {CW{1'b1}}; // value one

	// parameter check
	if (CW < pcmg_pkg::WEIGHT_IDX_W || CW > 16 || SYNC_W < 1) begin : g_bad_param
		$error("pcmg_top: unsupported channel or sync width");
	end

	// ---------------- register bus ----------------
	logic pready_q; // access-phase answer, one wait state
	logic [31:0] prdata_q; // registered read data
	logic pslverr_q; // unmapped address flag
	logic acc; // access completes this edge
	logic wr_acc; // write completes this edge
	logic hit; // address decodes to a register
	logic [31:0] rd_mux; // read data selection

	logic pend_q; // staged settings wait for vblank
	logic sh_after_q; // staged gamma-after mode
	logic act_after_q; // active gamma-after mode
	logic split_q; // split gamma, immediate
	logic gamut_en_q; // gamut enhancement, immediate
	logic signed [OFW-1:0] sh_in_off_q [3]; // staged input offsets, index 2 high
	logic signed [OFW-1:0] act_in_off_q [3]; // active input offsets
	logic signed [OFW-1:0] sh_out_off_q [3]; // staged output offsets
	logic signed [OFW-1:0] act_out_off_q [3]; // active output offsets
	logic signed [pcmg_pkg::COEF_W-1:0] sh_coef_q [9]; // staged coefficients
	logic signed [pcmg_pkg::COEF_W-1:0] act_coef_q [9]; // active coefficients
	logic load; // copy staged into active

	assign acc = psel & penable & pready_q;
	assign wr_acc = acc & pwrite;
	assign load = vblank_start & pend_q;

	// answer every access after one wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
		end
	end

	// read data and error come with the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (psel & penable & ~pready_q) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_q <= ~hit;
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// address decode and read mux; weights read back as zero
	always_comb begin
		hit = 1'b0;
		rd_mux = '0;
		if (paddr == pcmg_pkg::ADDR_MODE) begin
			hit = 1'b1;
			rd_mux[pcmg_pkg::MODE_AFTER_BIT] = sh_after_q;
		end
		if (paddr == pcmg_pkg::ADDR_PIPECFG) begin
			hit = 1'b1;
			rd_mux[pcmg_pkg::PIPECFG_SPLIT_BIT] = split_q;
		end
		if (paddr == pcmg_pkg::ADDR_GAMUT) begin
			hit = 1'b1;
			rd_mux[pcmg_pkg::GAMUT_EN_BIT] = gamut_en_q;
		end
		if (paddr == pcmg_pkg::ADDR_STATUS) begin
			hit = 1'b1;
			rd_mux[pcmg_pkg::STATUS_PEND_BIT] = pend_q;
		end
		for (int i = 0; i < 3; i++) begin
			if (paddr == pcmg_pkg::ADDR_IN_OFF + 8'(4 * (2 - i))) begin
				hit = 1'b1;
				rd_mux = 32'(sh_in_off_q[i]);
			end
			if (paddr == pcmg_pkg::ADDR_OUT_OFF + 8'(4 * (2 - i))) begin
				hit = 1'b1;
				rd_mux = 32'(sh_out_off_q[i]);
			end
		end
		for (int i = 0; i < 9; i++) begin
			if (paddr == pcmg_pkg::ADDR_COEF + 8'(4 * i)) begin
				hit = 1'b1;
				rd_mux = 32'(sh_coef_q[i]);
			end
		end
		if (paddr >= pcmg_pkg::ADDR_WEIGHT && paddr < pcmg_pkg::ADDR_WEIGHT_END) begin
			hit = 1'b1;
		end
	end

	// mode register; a write arms the vblank load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_after_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			if (wr_acc && paddr == pcmg_pkg::ADDR_MODE) begin
				sh_after_q <= pwdata[pcmg_pkg::MODE_AFTER_BIT];
				pend_q <= 1'b1;
			end else if (load) begin
				pend_q <= 1'b0;
			end
		end
	end

	// pipe config and gamut control act at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			split_q <= 1'b0;
			gamut_en_q <= 1'b0;
		end else begin
			if (wr_acc && paddr == pcmg_pkg::ADDR_PIPECFG) begin
				split_q <= pwdata[pcmg_pkg::PIPECFG_SPLIT_BIT];
			end
			if (wr_acc && paddr == pcmg_pkg::ADDR_GAMUT) begin
				gamut_en_q <= pwdata[pcmg_pkg::GAMUT_EN_BIT];
			end
		end
	end

	// active mode taken at vblank
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_after_q <= 1'b0;
		end else if (load) begin
			act_after_q <= sh_after_q;
		end
	end

	// offsets, staged and active, one per channel
	for (genvar c = 0; c < 3; c++) begin : g_off
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sh_in_off_q[c] <= '0;
				sh_out_off_q[c] <= '0;
				act_in_off_q[c] <= '0;
				act_out_off_q[c] <= '0;
			end else begin
				if (wr_acc && paddr == pcmg_pkg::ADDR_IN_OFF + 8'(4 * (2 - c))) begin
					sh_in_off_q[c] <= pwdata[OFW-1:0];
				end
				if (wr_acc && paddr == pcmg_pkg::ADDR_OUT_OFF + 8'(4 * (2 - c))) begin
					sh_out_off_q[c] <= pwdata[OFW-1:0];
				end
				if (load) begin
					act_in_off_q[c] <= sh_in_off_q[c];
					act_out_off_q[c] <= sh_out_off_q[c];
				end
			end
		end
	end

	// coefficients, staged and active; reset is identity
	for (genvar i = 0; i < 9; i++) begin : g_coef
		localparam logic [15:0] RST = (i % 4 == 0) ? pcmg_pkg::COEF_ONE : pcmg_pkg::COEF_ZERO;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sh_coef_q[i] <= RST;
				act_coef_q[i] <= RST;
			end else begin
				if (wr_acc && paddr == pcmg_pkg::ADDR_COEF + 8'(4 * i)) begin
					sh_coef_q[i] <= pwdata[pcmg_pkg::COEF_W-1:0];
				end
				if (load) begin
					act_coef_q[i] <= sh_coef_q[i];
				end
			end
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// ---------------- helpers ----------------
	// square-law gamma curve on a channel
	function automatic logic [CW-1:0] gam(input logic [CW-1:0] x);
		logic [2*CW-1:0] p;
		p = x * x;
		return p[2*CW-1:CW];
	endfunction

	// clamp a signed value into zero..one
	function automatic logic [CW-1:0] clamp(input logic signed [OW:0] v);
		if (v < 0) begin
			return '0;
		end else if (v > $signed({{(OW-CW+1){1'b0}}, CMAX})) begin
			return CMAX;
		end else begin
			return v[CW-1:0];
		end
	endfunction

	// ---------------- datapath ----------------
	logic [CW-1:0] in_q [1:NS-1][3]; // uncorrected colour, delayed per stage
	logic [NS-1:1] ge_q; // per-pixel gamma enable, per stage
	logic [NS-1:1] vld_q; // valid, per stage
	logic [SYNC_W-1:0] sync_q [1:NS-1]; // sync, per stage
	logic [pcmg_pkg::WEIGHT_W-1:0] w_q [2:NS-1]; // weight, per stage
	logic [pcmg_pkg::WEIGHT_W-1:0] w_rd; // weight from the table
	logic signed [IW-1:0] a_q [3]; // matrix input after offset
	logic signed [OW-1:0] m_res [3]; // matrix row results
	logic [CW-1:0] c_q [3]; // corrected colour
	logic [CW-1:0] ch_in [3]; // input split into channels
	logic [CW-1:0] smax; // largest input channel
	logic [CW-1:0] smin; // smallest input channel
	logic [CW-1:0] sat; // saturation measure
	logic pre_on; // gamma stage before the matrix
	logic post_on; // gamma stage after the matrix

	// channel split: msbs high (2), lsbs low (0)
	for (genvar c = 0; c < 3; c++) begin : g_split
		assign ch_in[c] = pix_in[c*CW +: CW];
	end

	// saturation as spread between channels
	always_comb begin
		smax = ch_in[0];
		smin = ch_in[0];
		for (int c = 1; c < 3; c++) begin
			if (ch_in[c] > smax) begin
				smax = ch_in[c];
			end
			if (ch_in[c] < smin) begin
				smin = ch_in[c];
			end
		end
		sat = smax - smin;
	end

	// weight table, indexed linearly by saturation
	pcmg_weight_mem #(
		.DW(pcmg_pkg::WEIGHT_W),
		.AW(pcmg_pkg::WEIGHT_IDX_W)
	) u_weight (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_acc && paddr >= pcmg_pkg::ADDR_WEIGHT && paddr < pcmg_pkg::ADDR_WEIGHT_END),
		.wr_addr(paddr[pcmg_pkg::WEIGHT_IDX_W+1:2]),
		.wr_data(pwdata[pcmg_pkg::WEIGHT_W-1:0]),
		.rd_addr(sat[CW-1 -: pcmg_pkg::WEIGHT_IDX_W]),
		.rd_data(w_rd)
	);

	// one enable drives both stages in split mode
	assign pre_on = split_q | ~act_after_q;
	assign post_on = split_q | act_after_q;

	// stage 1: capture pixel; delay line for input colour and control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 1; s < NS; s++) begin
				for (int c = 0; c < 3; c++) begin
					in_q[s][c] <= '0;
				end
				sync_q[s] <= '0;
			end
			ge_q <= '0;
			vld_q <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				in_q[1][c] <= ch_in[c];
			end
			sync_q[1] <= pix_in_sync;
			ge_q[1] <= pix_in_gamma_en;
			vld_q[1] <= pix_in_valid;
			for (int s = 2; s < NS; s++) begin
				in_q[s] <= in_q[s-1];
				sync_q[s] <= sync_q[s-1];
			end
			ge_q[NS-1:2] <= ge_q[NS-2:1];
			vld_q[NS-1:2] <= vld_q[NS-2:1];
		end
	end

	// weight delay; values above maximum saturate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 2; s < NS; s++) begin
				w_q[s] <= '0;
			end
		end else begin
			w_q[2] <= (w_rd > pcmg_pkg::WEIGHT_MAX) ? pcmg_pkg::WEIGHT_MAX : w_rd;
			for (int s = 3; s < NS; s++) begin
				w_q[s] <= w_q[s-1];
			end
		end
	end

	// stage 2: optional gamma then input offset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < 3; c++) begin
				a_q[c] <= '0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (ge_q[1] && pre_on) begin
					a_q[c] <= $signed({3'b000, gam(in_q[1][c])}) + IW'(act_in_off_q[c]);
				end else begin
					a_q[c] <= $signed({3'b000, in_q[1][c]}) + IW'(act_in_off_q[c]);
				end
			end
		end
	end

	// stage 3: matrix rows, row r uses coefficients 3(2-r)..3(2-r)+2
	for (genvar r = 0; r < 3; r++) begin : g_row
		pcmg_matrix_row #(
			.IW(IW),
			.OW(OW)
		) u_row (
			.pclk(pclk),
			.presetn(presetn),
			.in_high(a_q[2]),
			.in_med(a_q[1]),
			.in_low(a_q[0]),
			.coef_first(act_coef_q[3*(2-r)]),
			.coef_second(act_coef_q[3*(2-r)+1]),
			.coef_third(act_coef_q[3*(2-r)+2]),
			.result(m_res[r])
		);
	end

	// stage 4: output offset, clamp, optional gamma after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < 3; c++) begin
				c_q[c] <= '0;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (ge_q[3] && post_on) begin
					c_q[c] <= gam(clamp((OW+1)'(m_res[c]) + (OW+1)'(act_out_off_q[c])));
				end else begin
					c_q[c] <= clamp((OW+1)'(m_res[c]) + (OW+1)'(act_out_off_q[c]));
				end
			end
		end
	end

	// stage 5: blend input and corrected colour by weight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_out <= '0;
			pix_out_valid <= 1'b0;
			pix_out_sync <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (gamut_en_q) begin
					pix_out[c*CW +: CW] <= CW'(((CW+7)'(w_q[NS-1]) * in_q[NS-1][c]
						+ (CW+7)'(pcmg_pkg::WEIGHT_MAX - w_q[NS-1]) * c_q[c])
						>> pcmg_pkg::WEIGHT_SHIFT);
				end else begin
					pix_out[c*CW +: CW] <= c_q[c];
				end
			end
			pix_out_valid <= vld_q[NS-1];
			pix_out_sync <= sync_q[NS-1];
		end
	end
endmodule

/* File: pcmg_top_asserts.sv */
/*
 * pcmg_top_chk: port-level properties of the colour path, bound into pcmg_top.
 * assumes: one clock domain; the apb master holds a request until pready.
 */
`timescale 1ns/1ps
module pcmg_top_chk #(
	parameter int CW = 10,
	parameter int SYNC_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic vblank_start,
	input wire logic pix_in_valid,
	input wire logic [SYNC_W-1:0] pix_in_sync,
	input wire logic pix_out_valid,
	input wire logic [SYNC_W-1:0] pix_out_sync
);
	logic pend_q; // mirror of the load-pending flag
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a mode write arms the load, the vblank pulse takes it; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_q <= 1'b0;
		end else if (psel && penable && pready && pwrite && paddr == pcmg_pkg::ADDR_MODE) begin
			pend_q <= 1'b1;
		end else if (vblank_start) begin
			pend_q <= 1'b0;
		end
	end
	property p_rdy_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
	a_rdy_wait: assert property (p_rdy_wait)
		else $error("pready not one wait state after access start");
	property p_rdy_pulse; pready |=> !pready; endproperty
	a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
	property p_rdy_qual; pready |-> psel && penable; endproperty
	a_rdy_qual: assert property (p_rdy_qual) else $error("pready outside an access");
	property p_err_pair; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err_pair: assert property (p_err_pair) else $error("pslverr without pready or with data");
	property p_wr_zero; pready && pwrite |-> prdata == 32'h0; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("read data on a write");
	property p_err_map;
		pready && paddr[1:0] == 2'h0 |-> pslverr == ((paddr >= 8'h4c && paddr < 8'h80)
			|| paddr >= pcmg_pkg::ADDR_WEIGHT_END);
	endproperty
	a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");
	property p_pend; pready && !pwrite && paddr == pcmg_pkg::ADDR_STATUS |-> prdata[0] == pend_q;
	endproperty
	a_pend: assert property (p_pend)
		else $error("pending flag wrong");
	property p_lat_on;
		pix_in_valid |-> ##5 pix_out_valid && pix_out_sync == $past(pix_in_sync, 5);
	endproperty
	a_lat_on: assert property (p_lat_on)
		else $error("pixel or sync not out five clocks later");
	property p_lat_off; !pix_in_valid |-> ##5 !pix_out_valid; endproperty
	a_lat_off: assert property (p_lat_off)
		else $error("output valid without an input pixel");
endmodule
bind pcmg_top pcmg_top_chk #(.CW(CW), .SYNC_W(SYNC_W)) pcmg_top_chk_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .vblank_start(vblank_start),
	.pix_in_valid(pix_in_valid), .pix_in_sync(pix_in_sync), .pix_out_valid(pix_out_valid),
	.pix_out_sync(pix_out_sync));

/* File: pcmg_pix_src.sv */
/*
 * pcmg_pix_src: upstream blender stand-in feeding random pixels.
 * assumes: rnd changes every clock; pixels only while run is high.
 */
`timescale 1ns/1ps
module pcmg_pix_src #(
	parameter int CW = 10,
	parameter int SYNC_W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [31:0] rnd,
	output logic pix_in_valid,
	output logic [3*CW-1:0] pix_in,
	output logic pix_in_gamma_en,
	output logic [SYNC_W-1:0] pix_in_sync
);
	logic [63:0] mix; // widened random pattern
	assign mix = {rnd ^ {rnd[15:0], rnd[31:16]}, rnd};
	// data keeps changing between frames so stale values are never trusted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pix_in_valid <= 1'b0;
			pix_in <= '0;
			pix_in_gamma_en <= 1'b0;
			pix_in_sync <= '0;
		end else begin
			pix_in_valid <= run && rnd[2:0] != 3'h0; // gaps inside a burst
			pix_in <= mix[3*CW-1:0];
			pix_in_gamma_en <= rnd[5];
			pix_in_sync <= mix[40 +: SYNC_W];
		end
	end
endmodule

/* File: tb_top.sv */
/*
 * tb_top: self-checking bench for pcmg_top with a random pixel source.
 * assumes: design latency and register map as in pcmg_pkg.
 */
`timescale 1ns/1ps
module tb_top;
	localparam int CW = 10;
	localparam int SYNC_W = 3;
	localparam int LIMIT = 20000; // cycle ceiling, a run needs about 1500
	logic pclk, presetn, psel, penable, pwrite, vblank_start, run;
	logic pready, pslverr, pix_in_valid, pix_in_gamma_en, pix_out_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [3*CW-1:0] pix_in, pix_out;
	logic [SYNC_W-1:0] pix_in_sync, pix_out_sync;
	int n_fail, checks, cyc;
	int coef_s[9], coef_a[9], ioff_s[3], ioff_a[3], ooff_s[3], ooff_a[3], wt[16]; // settings model
	logic after_s, after_a, split_m, gam_m, pend_m;
	logic [29:0] expq[$]; // expected pixels in order
	pcmg_top #(.CW(CW), .SYNC_W(SYNC_W)) pcmg_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .vblank_start(vblank_start),
		.pix_in_valid(pix_in_valid), .pix_in(pix_in), .pix_in_gamma_en(pix_in_gamma_en),
		.pix_in_sync(pix_in_sync), .pix_out_valid(pix_out_valid), .pix_out(pix_out),
		.pix_out_sync(pix_out_sync));
	pcmg_pix_src #(.CW(CW), .SYNC_W(SYNC_W)) pcmg_pix_src_inst (.pclk(pclk), .presetn(presetn),
		.run(run), .rnd(rnd), .pix_in_valid(pix_in_valid), .pix_in(pix_in),
		.pix_in_gamma_en(pix_in_gamma_en), .pix_in_sync(pix_in_sync));
	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic complete_run();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// random source and hang guard
	always @(posedge pclk) begin
		rnd <= lfsr(rnd);
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data and error flag compared at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic experr);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_fail++;
		if (!w) chk(prdata, exp);
		chk({31'h0, pslverr}, {31'h0, experr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// reference colour path on the live settings
	function automatic logic [29:0] expv(input logic [29:0] p, input logic ge);
		int raw[3], t[3], o, s, w, mx, mn;
		logic [29:0] r;
		mx = 0;
		mn = 1023;
		for (int k = 0; k < 3; k++) begin
			raw[k] = p[29-10*k -: 10];
			t[k] = ((ge && (split_m || !after_a)) ? (raw[k] * raw[k]) >> 10 : raw[k]) + ioff_a[k];
			mx = (raw[k] > mx) ? raw[k] : mx;
			mn = (raw[k] < mn) ? raw[k] : mn;
		end
		w = wt[(mx - mn) >> 6];
		if (w > 32) w = 32;
		for (int j = 0; j < 3; j++) begin
			s = coef_a[3*j] * t[0] + coef_a[3*j+1] * t[1] + coef_a[3*j+2] * t[2];
			o = (s >>> 12) + ooff_a[j];
			o = (o < 0) ? 0 : (o > 1023) ? 1023 : o;
			if (ge && (split_m || after_a)) o = (o * o) >> 10;
			if (gam_m) o = (w * raw[j] + (32 - w) * o) >> 5;
			r[29-10*j -: 10] = o[9:0];
		end
		return r;
	endfunction
	// note each accepted pixel
	always @(posedge pclk) begin
		if (presetn === 1'b1 && pix_in_valid === 1'b1) expq.push_back(expv(pix_in, pix_in_gamma_en));
	end
	// compare each delivered pixel with the oldest note
	always @(posedge pclk) begin
		if (presetn === 1'b1 && pix_out_valid === 1'b1) begin
			if (expq.size() == 0) chk(32'h1, 32'h0);
			else chk({2'h0, pix_out}, {2'h0, expq.pop_front()});
		end
	end
	task automatic stream();
		@(posedge pclk);
		run <= 1'b1;
		repeat (24) @(posedge pclk);
		run <= 1'b0;
		repeat (10) @(posedge pclk);
	endtask
	// one arrangement: stage, check it waits for vblank, load, run again
	task automatic cfg(input int c);
		split_m = c[1];
		after_s = c[0];
		apb(1'b1, pcmg_pkg::ADDR_PIPECFG, 32'(split_m), 0, 0);
		for (int i = 0; i < 9; i++) begin
			coef_s[i] = int'(rnd[13:0]) - 8192;
			apb(1'b1, pcmg_pkg::ADDR_COEF + 8'(4*i), 32'(coef_s[i]), 0, 0);
		end
		for (int i = 0; i < 3; i++) begin
			ioff_s[i] = (c == 1) ? ((i == 1) ? -64 : -512) : int'(rnd[9:0]) - 512;
			ooff_s[i] = (c == 0) ? ((i == 1) ? 64 : 512) : int'(rnd[19:10]) - 512;
			apb(1'b1, pcmg_pkg::ADDR_IN_OFF + 8'(4*i), 32'(ioff_s[i]), 0, 0);
			apb(1'b1, pcmg_pkg::ADDR_OUT_OFF + 8'(4*i), 32'(ooff_s[i]), 0, 0);
		end
		apb(1'b1, pcmg_pkg::ADDR_MODE, 32'(after_s), 0, 0);
		pend_m = 1'b1;
		apb(1'b0, pcmg_pkg::ADDR_STATUS, 0, 1, 0);
		apb(1'b0, pcmg_pkg::ADDR_MODE, 0, 32'(after_s), 0);
		apb(1'b0, pcmg_pkg::ADDR_COEF + 8'h08, 0, 32'(coef_s[2]), 0);
		apb(1'b0, pcmg_pkg::ADDR_IN_OFF, 0, 32'(ioff_s[0]), 0);
		stream();
		@(posedge pclk);
		vblank_start <= 1'b1;
		@(posedge pclk);
		vblank_start <= 1'b0;
		coef_a = coef_s;
		ioff_a = ioff_s;
		ooff_a = ooff_s;
		after_a = after_s;
		pend_m = 1'b0;
		apb(1'b0, pcmg_pkg::ADDR_STATUS, 0, 0, 0);
		gam_m = c[2] && (c[0] || c[1]);
		apb(1'b1, pcmg_pkg::ADDR_GAMUT, 32'(gam_m), 0, 0);
		apb(1'b0, pcmg_pkg::ADDR_GAMUT, 0, 32'(gam_m), 0);
		apb(1'b0, pcmg_pkg::ADDR_PIPECFG, 0, 32'(split_m), 0);
		stream();
	endtask
	initial begin
		{psel, penable, pwrite, vblank_start, run, presetn} = 6'h0;
		{after_s, after_a, split_m, gam_m, pend_m} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		rnd = 32'h2809;
		{n_fail, checks, cyc} = {32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 9; i += 4) coef_a[i] = 4096;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, pcmg_pkg::ADDR_COEF, 0, 32'h1000, 0);
		apb(1'b0, pcmg_pkg::ADDR_COEF + 8'h04, 0, 0, 0);
		apb(1'b0, pcmg_pkg::ADDR_STATUS, 0, 0, 0);
		apb(1'b0, 8'h60, 0, 0, 1);
		apb(1'b1, 8'hc4, 32'hffff_ffff, 0, 1);
		for (int i = 0; i < 16; i++) begin
			wt[i] = (i == 15) ? 63 : (i == 0) ? 32 : int'(rnd[5:0]);
			apb(1'b1, pcmg_pkg::ADDR_WEIGHT + 8'(4*i), 32'(wt[i]), 0, 0);
		end
		apb(1'b0, pcmg_pkg::ADDR_WEIGHT, 0, 0, 0);
		for (int c = 0; c < 8; c++) cfg(c);
		chk(32'(expq.size()), 0);
		complete_run();
	end
endmodule
